// ===== rtl/acc_regs.svh
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ------------------------------------------------------------
// register indices, byte address is four times the index
// ------------------------------------------------------------
`define ACC_CSR_IDX 10'h034
`define ACC_RESH_IDX 10'h035
`define ACC_RESL_IDX 10'h036
`define ACC_IRQ_ST_IDX 10'h037
`define ACC_IRQ_MK_IDX 10'h038
`define ACC_PIN_IDX 10'h039

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ACC_CSR_DONE_BIT 7
`define ACC_CSR_SPEED_BIT 6
`define ACC_CSR_ON_BIT 5
`define ACC_RESL_CAL_BIT 4
`define ACC_RESL_SLOW_BIT 3
`define ACC_RESL_AMP_BIT 2
`define ACC_IRQ_OVWR_BIT 0
`define ACC_IRQ_HALT_BIT 1

// ------------------------------------------------------------
// reset values and timing
// ------------------------------------------------------------
`define ACC_RESULT_RST 10'h000
`define ACC_CLK_MHZ 125
`define ACC_STAB_NS 10000
`define ACC_SAMPLE_TICKS 3'h3
`define ACC_BIT_TICKS 2'h3
`define ACC_RESULT_MSB 4'h9

`endif

// ===== rtl/acc_pkg.sv
package acc_pkg;

  typedef enum logic [1:0] {
    ACC_OFF,
    ACC_STARTUP,
    ACC_SAMPLE,
    ACC_TRIAL
  } acc_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } acc_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } acc_apb_rsp_t;

  typedef struct packed {
    logic power_on;
    logic amp_sel;
    logic cal_en;
    logic [2:0] ch_sel;
    logic sample;
    logic [9:0] dac;
  } acc_ana_t;

  typedef struct packed {
    acc_state_t state;
    logic speed;
    logic on;
    logic [2:0] ch;
    logic cal;
    logic slow;
    logic amp;
    logic [9:0] result;
    logic done;
    logic [1:0] irq_st;
    logic [1:0] irq_mk;
    logic [1:0] div;
    logic [15:0] stab;
    logic [2:0] sub;
    logic [3:0] bit_idx;
    logic [9:0] sar;
    logic comp_s1;
    logic comp_s2;
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    logic irq;
    acc_apb_rsp_t rsp;
    acc_ana_t ana;
  } acc_state_rec_t;

endpackage

// ===== rtl/acc_conv.sv
// Register access over APB and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "acc_regs.svh"

module acc_conv #(
  parameter int STAB_NS = `ACC_STAB_NS
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire acc_pkg::acc_apb_req_t apb_req,
  output acc_pkg::acc_apb_rsp_t apb_rsp,
  input wire logic halt_mode,
  input wire logic comp_in,
  input wire logic [6:0] pin_in,
  output acc_pkg::acc_ana_t ana,
  output logic irq
);

  // least time rounds up to whole cycles
  localparam int STAB_CYC = (STAB_NS * `ACC_CLK_MHZ + 999) / 1000;

  acc_pkg::acc_state_rec_t st_ff;
  acc_pkg::acc_state_rec_t nxt_st;

  logic access;
  logic taken;
  logic wr_taken;
  logic rd_taken;
  logic run;
  logic tick;
  logic conv_end;
  logic ev_ovwr;
  logic ev_halt;
  logic [9:0] nsar;
  logic [3:0] nbit;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
    reg_hit = (addr[1:0] == 2'h0) && (addr[11:2] == idx);
  endfunction

  // converter clock: cpu/2, cpu, or cpu/4 when slow
  function automatic logic [1:0] div_lim(input logic speed, input logic slow);
    if (slow) begin
      div_lim = 2'h3;
    end else if (speed) begin
      div_lim = 2'h0;
    end else begin
      div_lim = 2'h1;
    end
  endfunction

  function automatic logic [31:0] rd_val(input acc_pkg::acc_state_rec_t s,
                                         input logic [11:0] addr);
    logic [7:0] v;
    v = 8'h00;
    if (reg_hit(addr, `ACC_CSR_IDX)) begin
      v[`ACC_CSR_DONE_BIT] = s.done;
      v[`ACC_CSR_SPEED_BIT] = s.speed;
      v[`ACC_CSR_ON_BIT] = s.on;
      v[2:0] = s.ch;
    end else if (reg_hit(addr, `ACC_RESH_IDX)) begin
      v = s.result[9:2];
    end else if (reg_hit(addr, `ACC_RESL_IDX)) begin
      v[`ACC_RESL_CAL_BIT] = s.cal;
      v[`ACC_RESL_SLOW_BIT] = s.slow;
      v[`ACC_RESL_AMP_BIT] = s.amp;
      v[1:0] = s.result[1:0];
    end else if (reg_hit(addr, `ACC_IRQ_ST_IDX)) begin
      v[1:0] = s.irq_st;
    end else if (reg_hit(addr, `ACC_IRQ_MK_IDX)) begin
      v[1:0] = s.irq_mk;
    end else if (reg_hit(addr, `ACC_PIN_IDX)) begin
      v[6:0] = s.pin_s2;
    end
    rd_val = {24'h000000, v};
  endfunction

  function automatic logic mapped(input logic [11:0] addr);
    mapped = reg_hit(addr, `ACC_CSR_IDX) || reg_hit(addr, `ACC_RESH_IDX) ||
             reg_hit(addr, `ACC_RESL_IDX) || reg_hit(addr, `ACC_IRQ_ST_IDX) ||
             reg_hit(addr, `ACC_IRQ_MK_IDX) || reg_hit(addr, `ACC_PIN_IDX);
  endfunction

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    conv_end = 1'b0;
    ev_ovwr = 1'b0;
    ev_halt = 1'b0;
    tick = 1'b0;
    nsar = st_ff.sar;
    nbit = st_ff.bit_idx;

    // pin synchronisers
    nxt_st.comp_s1 = comp_in;
    nxt_st.comp_s2 = st_ff.comp_s1;
    nxt_st.pin_s1 = pin_in;
    nxt_st.pin_s2 = st_ff.pin_s1;

    // apb: one wait state so read data comes from a flop
    access = apb_req.psel && apb_req.penable;
    taken = access && st_ff.rsp.pready;
    wr_taken = taken && apb_req.pwrite;
    rd_taken = taken && !apb_req.pwrite;
    nxt_st.rsp.pready = access && !st_ff.rsp.pready;
    if (access && !st_ff.rsp.pready) begin
      nxt_st.rsp.prdata = apb_req.pwrite ? 32'h00000000 : rd_val(st_ff, apb_req.paddr);
      nxt_st.rsp.pslverr = !mapped(apb_req.paddr);
    end

    if (wr_taken) begin
      if (reg_hit(apb_req.paddr, `ACC_CSR_IDX)) begin
        nxt_st.speed = apb_req.pwdata[`ACC_CSR_SPEED_BIT];
        nxt_st.on = apb_req.pwdata[`ACC_CSR_ON_BIT];
        nxt_st.ch = apb_req.pwdata[2:0];
      end
      if (reg_hit(apb_req.paddr, `ACC_RESL_IDX)) begin
        nxt_st.cal = apb_req.pwdata[`ACC_RESL_CAL_BIT];
        nxt_st.slow = apb_req.pwdata[`ACC_RESL_SLOW_BIT];
        nxt_st.amp = apb_req.pwdata[`ACC_RESL_AMP_BIT];
      end
      if (reg_hit(apb_req.paddr, `ACC_IRQ_MK_IDX)) begin
        nxt_st.irq_mk = apb_req.pwdata[1:0];
      end
    end

    // idle sleep has no input here, so conversion never notices it
    run = st_ff.on && !halt_mode;

    if (st_ff.state == acc_pkg::ACC_OFF) begin
      nxt_st.div = 2'h0;
    end else if (st_ff.div == div_lim(st_ff.speed, st_ff.slow)) begin
      tick = 1'b1;
      nxt_st.div = 2'h0;
    end else begin
      nxt_st.div = st_ff.div + 2'h1;
    end

    // ------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------
    case (st_ff.state)
      acc_pkg::ACC_OFF: begin
        if (run) begin
          // amp shares converter power, so one startup covers both
          nxt_st.state = acc_pkg::ACC_STARTUP;
          nxt_st.stab = 16'(STAB_CYC - 1);
        end
      end
      acc_pkg::ACC_STARTUP: begin
        if (st_ff.stab == 16'h0000) begin
          nxt_st.state = acc_pkg::ACC_SAMPLE;
          nxt_st.sub = 3'h0;
        end else begin
          nxt_st.stab = st_ff.stab - 16'h0001;
        end
      end
      acc_pkg::ACC_SAMPLE: begin
        if (tick) begin
          if (st_ff.sub == `ACC_SAMPLE_TICKS) begin
            nxt_st.state = acc_pkg::ACC_TRIAL;
            nxt_st.sub = 3'h0;
            nxt_st.bit_idx = `ACC_RESULT_MSB;
            nxt_st.sar = 10'h200;
          end else begin
            nxt_st.sub = st_ff.sub + 3'h1;
          end
        end
      end
      acc_pkg::ACC_TRIAL: begin
        if (tick) begin
          if (st_ff.sub[1:0] == `ACC_BIT_TICKS) begin
            nxt_st.sub = 3'h0;
            // comparator low drops the trial bit; saturation falls out
            if (!st_ff.comp_s2) begin
              nsar[st_ff.bit_idx] = 1'b0;
            end
            if (st_ff.bit_idx == 4'h0) begin
              conv_end = 1'b1;
              nxt_st.result = nsar;
              ev_ovwr = st_ff.done;
              nxt_st.sar = 10'h000;
              nxt_st.state = acc_pkg::ACC_SAMPLE;
            end else begin
              nbit = st_ff.bit_idx - 4'h1;
              nsar[nbit] = 1'b1;
              nxt_st.bit_idx = nbit;
              nxt_st.sar = nsar;
            end
          end else begin
            nxt_st.sub = st_ff.sub + 3'h1;
          end
        end
      end
      default: begin
        nxt_st.state = acc_pkg::ACC_OFF;
      end
    endcase

    // off or deep stop aborts at once; a partial result is dropped
    if (!run) begin
      ev_halt = halt_mode && st_ff.on && (st_ff.state != acc_pkg::ACC_OFF);
      conv_end = 1'b0;
      ev_ovwr = 1'b0;
      nxt_st.result = st_ff.result;
      nxt_st.state = acc_pkg::ACC_OFF;
      nxt_st.sar = 10'h000;
      nxt_st.sub = 3'h0;
    end

    // set beats the clearing read in the same cycle
    nxt_st.done = (st_ff.done && !(rd_taken && reg_hit(apb_req.paddr, `ACC_RESH_IDX)))
                  || conv_end;

    // only overwrite and stop-abort raise the line, never completion
    nxt_st.irq_st = st_ff.irq_st;
    if (wr_taken && reg_hit(apb_req.paddr, `ACC_IRQ_ST_IDX)) begin
      nxt_st.irq_st = st_ff.irq_st & ~apb_req.pwdata[1:0];
    end
    nxt_st.irq_st[`ACC_IRQ_OVWR_BIT] = nxt_st.irq_st[`ACC_IRQ_OVWR_BIT] | ev_ovwr;
    nxt_st.irq_st[`ACC_IRQ_HALT_BIT] = nxt_st.irq_st[`ACC_IRQ_HALT_BIT] | ev_halt;
    nxt_st.irq = |(nxt_st.irq_st & nxt_st.irq_mk);

    // analog front end controls
    nxt_st.ana.power_on = (nxt_st.state != acc_pkg::ACC_OFF);
    nxt_st.ana.amp_sel = nxt_st.amp;
    nxt_st.ana.cal_en = nxt_st.cal;
    nxt_st.ana.ch_sel = nxt_st.ch;
    nxt_st.ana.sample = (nxt_st.state == acc_pkg::ACC_SAMPLE);
    nxt_st.ana.dac = nxt_st.sar;
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.state <= acc_pkg::ACC_OFF;
      st_ff.result <= `ACC_RESULT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign apb_rsp = st_ff.rsp;
  assign ana = st_ff.ana;
  assign irq = st_ff.irq;

endmodule
`default_nettype wire

// ===== sim/acc_conv_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module acc_conv_monitor #(
  parameter int STAB_NS = 10000
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire acc_pkg::acc_apb_req_t apb_req,
  input wire acc_pkg::acc_apb_rsp_t apb_rsp,
  input wire logic halt_mode,
  input wire logic comp_in,
  input wire logic [6:0] pin_in,
  input wire acc_pkg::acc_ana_t ana,
  input wire logic irq
);
  // ----------
  // apb and converter checks
  // ----------
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  wire logic acc = apb_req.psel && apb_req.penable && apb_rsp.pready;
  wire logic wr_ctrl = acc && apb_req.pwrite && apb_req.paddr == 12'h0d0;
  wire logic mapped = (apb_req.paddr[1:0] == 2'h0) &&
                      (apb_req.paddr[11:2] inside {[10'h034:10'h039]});
  pready_pulse_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held too long");
  one_wait_a: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready)
    else $error("pready not after one wait state");
  slverr_map_a: assert property (acc |-> apb_rsp.pslverr == !mapped)
    else $error("pslverr does not match address map");
  prdata_zero_a: assert property (acc |-> apb_rsp.prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  halt_off_a: assert property (halt_mode ##1 halt_mode |-> !ana.power_on)
    else $error("converter powered in deep stop");
  off_stop_a: assert property (wr_ctrl && !apb_req.pwdata[5] |-> ##[2:3] !ana.power_on)
    else $error("converter still on after clear");
  on_start_a: assert property (
    wr_ctrl && apb_req.pwdata[5] && !halt_mode |-> ##[1:3] ana.power_on)
    else $error("converter did not power up");
  startup_hold_a: assert property ($rose(ana.power_on) |-> !ana.sample [*8])
    else $error("sampling before stabilization");
  trial_msb_a: assert property ($fell(ana.sample) && ana.power_on |-> ana.dac == 10'h200)
    else $error("first trial is not the top bit");
  sample_power_a: assert property (ana.sample |-> ana.power_on)
    else $error("sampling while unpowered");
  cover property (acc && !apb_req.pwrite && apb_req.paddr == 12'h0d4);
  cover property ($rose(irq));
  cover property (halt_mode && ana.power_on);
endmodule
bind acc_conv acc_conv_monitor #(.STAB_NS(STAB_NS)) mon (.core_clk, .reset, .apb_req,
  .apb_rsp, .halt_mode, .comp_in, .pin_in, .ana, .irq);
`default_nettype wire

// ===== sim/acc_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module acc_src_model (
  input wire logic core_clk,
  input wire acc_pkg::acc_ana_t ana,
  input wire logic [6:0][9:0] level,
  output logic comp_in
);
  logic [12:0] v;
  logic flip = 1'b0;
  always @(posedge core_clk) flip <= !flip;
  always_comb begin
    v = (ana.ch_sel == 3'h7) ? 13'h0 : {3'h0, level[ana.ch_sel]};
    if (ana.amp_sel) v = ana.cal_en ? 13'h0 : {v[9:0], 3'h0};
    // unpowered comparator gives no stable answer
    comp_in = ana.power_on ? (v >= {3'h0, ana.dac}) : flip;
  end
endmodule
`default_nettype wire

// ===== sim/adc_conversion_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_tb;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic halt_mode = 1'b0;
  logic comp_in;
  logic [6:0] pin_in = 7'h00;
  logic [6:0][9:0] level = '0;
  acc_pkg::acc_apb_req_t apb_req = '0;
  acc_pkg::acc_apb_rsp_t apb_rsp;
  acc_pkg::acc_ana_t ana;
  logic irq;
  int failures = 0;
  int n_checks = 0;
  logic [31:0] seed = 32'h0000_8cd8;
  logic [31:0] rd;
  logic er;
  logic [1:0] lo;
  always #4 core_clk = ~core_clk;
  // short stabilization keeps the run brief
  acc_conv #(.STAB_NS(80)) dut (.core_clk, .reset, .apb_req, .apb_rsp, .halt_mode,
    .comp_in, .pin_in, .ana, .irq);
  acc_src_model src (.core_clk, .ana, .level, .comp_in);
  // ----------
  // helpers
  // ----------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [9:0] exp_code(logic [9:0] lv, logic amp);
    logic [12:0] g;
    g = amp ? {lv, 3'h0} : {3'h0, lv};
    return (g > 13'h3ff) ? 10'h3ff : g[9:0];
  endfunction
  task automatic complete_run();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
    @(posedge core_clk);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h0d0, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 100);
    if (n >= 100) failures++;
  endtask
  // md: bit3 speed, bit2 cal, bit1 slow, bit0 amp
  task automatic conv(logic [2:0] ch, logic [3:0] md);
    logic [9:0] lv;
    apb(1'b1, 12'h0d8, {27'h0, md[2:0], 2'h0});
    apb(1'b1, 12'h0d0, {24'h0, 1'b0, md[3], 1'b1, 2'h0, ch});
    chk("channel", ch, ana.ch_sel);
    chk("amp", md[0], ana.amp_sel);
    chk("cal", md[2], ana.cal_en);
    repeat (2) begin
      wait_done();
      apb(1'b0, 12'h0d4, 32'h0);
    end
    wait_done();
    apb(1'b0, 12'h0d8, 32'h0);
    lo = rd[1:0];
    chk("low ctrl", md[2:0], rd[4:2]);
    apb(1'b0, 12'h0d4, 32'h0);
    // calibration grounds the amplifier input only when the amplifier is in the path
    lv = (md[2] && md[0]) ? 10'h000 : level[ch];
    chk("result", exp_code(lv, md[0]), {rd[7:0], lo});
    apb(1'b0, 12'h0d0, 32'h0);
    chk("done cleared", 1'b0, rd[7]);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    complete_run();
  end
  // ----------
  // scenarios
  // ----------
  initial begin
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, 12'h0d0, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 12'h0d8, 32'h0);
    chk("low reset", 32'h0, rd);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped", 1'b1, er);
    pin_in <= 7'(rnd());
    level <= {50'(rnd()), 10'h000, 10'h3ff};
    for (int c = 0; c < 7; c++) begin
      if (c > 1) level[c] <= 10'(rnd());
      conv(3'(c), (c < 2) ? 4'h0 : 4'(rnd()));
    end
    level[3] <= 10'h05a;
    level[4] <= 10'h2c1;
    conv(3'h3, 4'h9);
    conv(3'h4, 4'h3);
    conv(3'h5, 4'h5);
    apb(1'b0, 12'h0e4, 32'h0);
    chk("pins", pin_in, rd);
    // done cleared before both events are enabled, then a fresh completion is awaited
    apb(1'b0, 12'h0d4, 32'h0);
    apb(1'b1, 12'h0dc, 32'h3);
    apb(1'b1, 12'h0e0, 32'h3);
    wait_done();
    chk("no done irq", 1'b0, irq);
    for (int n = 0; n < 400 && irq !== 1'b1; n++) @(posedge core_clk);
    chk("irq raised", 1'b1, irq);
    apb(1'b1, 12'h0e0, 32'h0);
    chk("irq masked", 1'b0, irq);
    apb(1'b0, 12'h0d4, 32'h0);
    apb(1'b1, 12'h0dc, 32'h1);
    apb(1'b0, 12'h0dc, 32'h0);
    chk("status cleared", 1'b0, rd[0]);
    halt_mode <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk("stop power", 1'b0, ana.power_on);
    halt_mode <= 1'b0;
    apb(1'b1, 12'h0d0, 32'h0);
    repeat (3) @(posedge core_clk);
    chk("off power", 1'b0, ana.power_on);
    apb(1'b0, 12'h0dc, 32'h0);
    chk("stop status", 1'b1, rd[1]);
    complete_run();
  end
endmodule
`default_nettype wire
